//--- logic/alhai_consts.svh
// Constants for the limit, home and abort input block
`ifndef ALHAI_CONSTS_SVH
`define ALHAI_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define ALHAI_AXES 8
`define ALHAI_GP_W 24
`define ALHAI_GP_MAX ((`ALHAI_AXES > 4) ? 5'd24 : 5'd8)
`define ALHAI_NUM_RATES 5
`define ALHAI_SYNC_W 57

// ****************************************
// Bit positions inside the synchroniser vector
// ****************************************
`define ALHAI_POS_FWD 0
`define ALHAI_POS_REV 8
`define ALHAI_POS_HOME 16
`define ALHAI_POS_IDX 24
`define ALHAI_POS_ABORT 32
`define ALHAI_POS_GP 33

// ****************************************
// Register byte offsets
// ****************************************
`define ALHAI_OFF_CTRL 8'h00
`define ALHAI_OFF_BEGIN 8'h04
`define ALHAI_OFF_STATUS 8'h08
`define ALHAI_OFF_LIMITS 8'h0c
`define ALHAI_OFF_HOME 8'h10
`define ALHAI_OFF_GPIN 8'h14
`define ALHAI_OFF_GPIDX 8'h18
`define ALHAI_OFF_GPBIT 8'h1c
`define ALHAI_OFF_RATE0 8'h20
`define ALHAI_OFF_SERVO 8'h34

// ****************************************
// Fields and reset values
// ****************************************
`define ALHAI_CTRL_ROUTINE 0
`define ALHAI_CTRL_KILL 1
`define ALHAI_CTRL_OOF_LSB 8
`define ALHAI_KILL_RESET 1'b1
`define ALHAI_OOF_RESET 8'h00
`define ALHAI_SERVO_RESET 8'hff
// Begin refused toward a tripped limit, code 22 decimal
`define ALHAI_ERR_BEGIN_LIMIT 8'h16
`define ALHAI_RESP_OKAY 2'b00
`define ALHAI_RESP_SLVERR 2'b10

`endif

//--- logic/alhai_pkg.sv
// Types shared by the limit, home and abort input block
package alhai_pkg;

    typedef enum logic [1:0] {ALHAI_STOP_NONE, ALHAI_STOP_LIMIT, ALHAI_STOP_RAMP, ALHAI_STOP_FAST} alhai_stop_t;

    typedef enum logic [1:0] {ALHAI_MODE_PLAIN, ALHAI_MODE_EDGE, ALHAI_MODE_INDEX, ALHAI_MODE_FULL} alhai_mode_t;

    typedef enum logic [2:0] {HS_IDLE, HS_SLEW, HS_STOP1, HS_APPR, HS_SEEK, HS_STOP2, HS_RET, HS_RWAIT} alhai_hstate_t;

    typedef struct packed {
        alhai_hstate_t st;
        alhai_mode_t mode;
        logic fwd;
        logic slow;
        logic ret;
        logic zero;
    } alhai_seq_t;

    typedef struct packed {
        logic [56:0] meta;
        logic [56:0] lvl;
        logic [56:0] prev;
    } alhai_sync_t;

endpackage : alhai_pkg

//--- logic/alhai_home_if.sv
// Per-axis link between the register core and its homing sequencer
interface alhai_home_if;
    import alhai_pkg::*;
    logic start;
    alhai_mode_t mode;
    logic home_lvl;
    logic home_edge;
    logic idx_rise;
    logic stopped;
    logic cancel;
    logic jog;
    logic fwd;
    logic slow;
    logic decel;
    logic ret;
    logic zero;
    logic busy;
    modport ctl (output start, mode, home_lvl, home_edge, idx_rise, stopped, cancel,
                 input jog, fwd, slow, decel, ret, zero, busy);
    modport seq (input start, mode, home_lvl, home_edge, idx_rise, stopped, cancel,
                 output jog, fwd, slow, decel, ret, zero, busy);
endinterface : alhai_home_if

//--- logic/alhai_sync.sv
// Two-flop synchroniser and transition detector for all switch inputs
`include "alhai_consts.svh"
module alhai_sync import alhai_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ALHAI_SYNC_W-1:0] raw,
    output logic [`ALHAI_SYNC_W-1:0] lvl,
    output logic [`ALHAI_SYNC_W-1:0] edg
);
    alhai_sync_t q;
    alhai_sync_t d;

    // ****************************************
    // Synchroniser
    // ****************************************
    // two flops first
    // Meta stage feeds only the level stage; edges compare settled flops
    always_comb begin
        d = q;
        d.meta = raw;
        d.lvl = q.meta;
        d.prev = q.lvl;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lvl = q.lvl;
    assign edg = q.lvl ^ q.prev;
endmodule // alhai_sync

//--- logic/alhai_home_seq.sv
// Homing sequencer for one axis: edge, index and combined searches
module alhai_home_seq import alhai_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    alhai_home_if.seq hif
);
    alhai_seq_t q;
    alhai_seq_t d;

    // ****************************************
    // Sequence
    // ****************************************
    always_comb begin
        d = q;
        d.ret = 1'b0;
        d.zero = 1'b0;
        case (q.st)
            HS_IDLE: if (hif.start) begin
                d.mode = hif.mode;
                d.slow = 1'b0;
                d.fwd = (hif.mode == ALHAI_MODE_INDEX) ? 1'b1 : hif.home_lvl;
                d.st = HS_SLEW;
            end
            HS_SLEW: begin
                if (q.mode == ALHAI_MODE_INDEX) begin
                    if (hif.idx_rise) begin
                        d.st = HS_STOP2;
                    end
                end else if (hif.home_edge) begin
                    d.st = (q.mode == ALHAI_MODE_FULL) ? HS_STOP1 : HS_STOP2;
                end
            end
            HS_STOP1: if (hif.stopped) begin
                d.fwd = ~q.fwd;
                d.slow = 1'b1;
                d.st = HS_APPR;
            end
            HS_APPR: if (hif.home_edge) begin
                d.fwd = 1'b1;
                d.st = HS_SEEK;
            end
            HS_SEEK: if (hif.idx_rise) begin
                d.st = HS_STOP2;
            end
            HS_STOP2: if (hif.stopped) begin
                if (q.mode == ALHAI_MODE_EDGE) begin
                    d.st = HS_IDLE;
                end else begin
                    d.ret = 1'b1;
                    d.slow = 1'b1;
                    d.st = HS_RET;
                end
            end
            // Wait for the return move to leave rest first
            HS_RET: if (!hif.stopped) begin
                d.st = HS_RWAIT;
            end
            HS_RWAIT: if (hif.stopped) begin
                d.zero = (q.mode == ALHAI_MODE_FULL);
                d.st = HS_IDLE;
            end
            default: d.st = HS_IDLE;
        endcase
        // Limit trip or abort ends any search
        if (hif.cancel) begin
            d.st = HS_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{st: HS_IDLE, mode: ALHAI_MODE_PLAIN, default: '0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign hif.jog = (q.st == HS_SLEW) || (q.st == HS_APPR) || (q.st == HS_SEEK);
    assign hif.decel = (q.st == HS_STOP1) || (q.st == HS_STOP2);
    assign hif.busy = (q.st != HS_IDLE);
    assign hif.fwd = q.fwd;
    assign hif.slow = q.slow;
    assign hif.ret = q.ret;
    assign hif.zero = q.zero;
endmodule // alhai_home_seq

//--- logic/alhai_core.sv
// Limit, home, abort and general input handling with an AXI4-Lite register file
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "alhai_consts.svh"

// Functional notes
// - Active forward limit blocks forward motion of that axis at once.
// - Active reverse limit blocks reverse motion of that axis at once.
// - Limit trip while moving gives decelerated stop at limit stop rate.
// - After limit trip the motor stays servoed, holding position.
// - Limit trip branches thread zero to trip routine if routine exists.
// - Begin toward an active limit is refused with error code 022.
// - Forward and reverse limit states readable per axis as 0 or 1.
// - Every home input transition flips the home logic state.
// - Edge search: ramp, cruise until home transition, then ramp down.
// - Edge search goes forward when home level is high, else reverse.
// - Index search: cruise to index rise, stop, return at approach rate.
// - Full homing: stop, reverse slowly, then forward slowly to index.
// - Full homing: stop after index, return to it, load zero position.
// - Home state reads 0 when low and 1 when high.
// - Abort transition halts motion commands at once, no ramp.
// - Abort switches off axes with motor-off-on-fault enabled.
// - Abort stops other axes fastest, keeping servo on.
// - Abort terminates programs by default; configurable.
// - General inputs readable one by one, indices 1 to 8.
// - More than four axes extends the indices to 1 to 24.
module alhai_core import alhai_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] fwd_limit_in,
    input wire logic [7:0] rev_limit_in,
    input wire logic [7:0] home_in,
    input wire logic [7:0] index_in,
    input wire logic abort_in,
    input wire logic [23:0] gp_in,
    input wire logic [7:0] axis_moving,
    input wire logic [7:0] axis_stopped,
    output logic [7:0] fwd_inhibit,
    output logic [7:0] rev_inhibit,
    output logic [15:0] axis_stop_sel,
    output logic [7:0] motor_enable,
    output logic motion_halt,
    output logic [7:0] begin_go,
    output logic [7:0] begin_fwd,
    output logic [7:0] home_jog,
    output logic [7:0] home_jog_fwd,
    output logic [7:0] home_slow,
    output logic [7:0] home_return,
    output logic [7:0] pos_zero_load,
    output logic thread0_branch,
    output logic prog_kill,
    output logic [31:0] ramp_up_rate,
    output logic [31:0] ramp_down_rate,
    output logic [31:0] cruise_rate,
    output logic [31:0] homing_approach_rate,
    output logic [31:0] limit_stop_decel
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [1:0] rr;
        logic [31:0] rd;
        logic routine_en;
        logic kill_en;
        logic [7:0] oof;
        logic [7:0] beg;
        logic [7:0] err;
        logic [4:0] gp_idx;
        logic [4:0][31:0] rate;
        logic primed;
        logic [7:0] home_tgl;
        logic [7:0] motor_on;
        logic [7:0] lim_stop;
        logic [7:0] fast_stop;
        logic [7:0] go;
        logic [7:0] go_fwd;
        logic [7:0] hstart;
        alhai_mode_t hmode;
        logic branch;
        logic kill;
        logic halt;
    } alhai_core_t;

    alhai_core_t q;
    alhai_core_t d;
    logic [`ALHAI_SYNC_W-1:0] lvl;
    logic [`ALHAI_SYNC_W-1:0] edg;
    logic [7:0] lim_f;
    logic [7:0] lim_r;
    logic [7:0] trip;
    logic abort_edge;
    logic [7:0] busy;
    logic [7:0] decel;
    logic [7:0] h_ret;
    logic [7:0] h_zero;
    logic [7:0] h_jog;
    logic [7:0] h_fwd;
    logic [7:0] h_slow;
    logic [2:0] b_axis;
    alhai_mode_t b_mode;
    logic b_dir;
    logic [5:0] rd_word;
    logic [2:0] rd_rate;
    logic [5:0] wr_word;
    logic [2:0] wr_rate;
    logic gp_ok;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // Input conditioning
    // ****************************************
    // synchronise every switch and general input
    alhai_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw({gp_in, abort_in, index_in, home_in, rev_limit_in, fwd_limit_in}),
        .lvl(lvl),
        .edg(edg)
    );

    // Limit levels and fresh activations
    assign lim_f = lvl[`ALHAI_POS_FWD +: 8];
    assign lim_r = lvl[`ALHAI_POS_REV +: 8];
    assign trip = (edg[`ALHAI_POS_FWD +: 8] & lim_f) | (edg[`ALHAI_POS_REV +: 8] & lim_r);
    assign abort_edge = edg[`ALHAI_POS_ABORT];
    assign fwd_inhibit = lim_f;
    assign rev_inhibit = lim_r;

    // Begin request fields, from the held write data
    assign b_axis = q.w_d[2:0];
    assign b_mode = alhai_mode_t'(q.w_d[5:4]);
    // Effective direction as the move would start
    assign b_dir = (b_mode == ALHAI_MODE_PLAIN) ? q.w_d[3] :
                   (b_mode == ALHAI_MODE_INDEX) ? 1'b1 : q.home_tgl[b_axis];

    // Word indices for the rate block
    assign wr_word = q.aw_a[7:2];
    assign rd_word = s_axi_araddr[7:2];
    assign wr_rate = 3'(wr_word - `ALHAI_OFF_RATE0 / 4);
    assign rd_rate = 3'(rd_word - `ALHAI_OFF_RATE0 / 4);
    // index range widens with axis count
    assign gp_ok = (q.gp_idx != 5'h00) && (q.gp_idx <= `ALHAI_GP_MAX);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.go = '0;
        d.hstart = '0;
        d.branch = 1'b0;
        d.kill = 1'b0;
        d.halt = 1'b0;

        // home state toggles per transition
        // Primed once from the level just out of reset, and edges then keep it reading as the level
        if (!q.primed) begin
            d.primed = 1'b1;
            d.home_tgl = lvl[`ALHAI_POS_HOME +: 8];
        end else begin
            d.home_tgl = q.home_tgl ^ edg[`ALHAI_POS_HOME +: 8];
        end

        // Stops end when the axis reaches rest; a new cause wins
        d.lim_stop = q.lim_stop & ~axis_stopped;
        d.fast_stop = q.fast_stop & ~axis_stopped;
        d.lim_stop = d.lim_stop | (trip & axis_moving);
        d.branch = (|trip) & q.routine_en;

        if (abort_edge) begin
            d.halt = 1'b1;
            d.motor_on = q.motor_on & ~q.oof;
            d.fast_stop = d.fast_stop | ~q.oof;
            d.kill = q.kill_en;
        end

        // AXI write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_v = 1'b1;
            d.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_v = 1'b1;
            d.w_d = s_axi_wdata;
            d.w_s = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bv = 1'b0;
        end

        // Register write once both halves are held
        if (q.aw_v && q.w_v) begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.bv = 1'b1;
            d.br = `ALHAI_RESP_OKAY;
            if (q.aw_a >= `ALHAI_OFF_RATE0 && q.aw_a < `ALHAI_OFF_SERVO && q.aw_a[1:0] == 2'b00) begin
                d.rate[wr_rate] = wmerge(q.rate[wr_rate], q.w_d, q.w_s);
            end else begin
                case (q.aw_a)
                    `ALHAI_OFF_CTRL: begin
                        if (q.w_s[0]) begin
                            d.routine_en = q.w_d[`ALHAI_CTRL_ROUTINE];
                            d.kill_en = q.w_d[`ALHAI_CTRL_KILL];
                        end
                        if (q.w_s[1]) begin
                            d.oof = q.w_d[`ALHAI_CTRL_OOF_LSB +: 8];
                        end
                    end
                    `ALHAI_OFF_BEGIN: begin
                        d.beg = q.w_d[7:0];
                        if (b_dir ? lim_f[b_axis] : lim_r[b_axis]) begin
                            d.err = `ALHAI_ERR_BEGIN_LIMIT;
                        end else if (!busy[b_axis]) begin
                            if (b_mode == ALHAI_MODE_PLAIN) begin
                                d.go[b_axis] = 1'b1;
                                d.go_fwd[b_axis] = q.w_d[3];
                            end else begin
                                d.hstart[b_axis] = 1'b1;
                                d.hmode = b_mode;
                            end
                        end
                    end
                    // Any write clears the error code
                    `ALHAI_OFF_STATUS: d.err = 8'h00;
                    `ALHAI_OFF_GPIDX: begin
                        if (q.w_s[0]) begin
                            d.gp_idx = q.w_d[4:0];
                        end
                    end
                    // Write one re-energises the motor
                    `ALHAI_OFF_SERVO: begin
                        if (q.w_s[0]) begin
                            d.motor_on = d.motor_on | q.w_d[7:0];
                        end
                    end
                    `ALHAI_OFF_LIMITS, `ALHAI_OFF_HOME, `ALHAI_OFF_GPIN, `ALHAI_OFF_GPBIT: begin
                        d.br = `ALHAI_RESP_OKAY;
                    end
                    default: d.br = `ALHAI_RESP_SLVERR;
                endcase
            end
        end

        // Read channel, one outstanding answer
        if (q.rv && s_axi_rready) begin
            d.rv = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rv = 1'b1;
            d.rr = `ALHAI_RESP_OKAY;
            d.rd = 32'h0000_0000;
            if (s_axi_araddr >= `ALHAI_OFF_RATE0 && s_axi_araddr < `ALHAI_OFF_SERVO && s_axi_araddr[1:0] == 2'b00) begin
                d.rd = q.rate[rd_rate];
            end else begin
                case (s_axi_araddr)
                    `ALHAI_OFF_CTRL: d.rd = {16'h0000, q.oof, 6'h00, q.kill_en, q.routine_en};
                    `ALHAI_OFF_BEGIN: d.rd = {24'h000000, q.beg};
                    `ALHAI_OFF_STATUS: d.rd = {24'h000000, q.err};
                    `ALHAI_OFF_LIMITS: d.rd = {16'h0000, lim_r, lim_f};
                    `ALHAI_OFF_HOME: d.rd = {16'h0000, busy, q.home_tgl};
                    `ALHAI_OFF_GPIN: d.rd = {8'h00, lvl[`ALHAI_POS_GP +: `ALHAI_GP_W]};
                    `ALHAI_OFF_GPIDX: d.rd = {27'h0000000, q.gp_idx};
                    `ALHAI_OFF_GPBIT: d.rd = {31'h00000000, gp_ok & lvl[`ALHAI_POS_GP + 5'(q.gp_idx - 5'd1)]};
                    `ALHAI_OFF_SERVO: d.rd = {24'h000000, q.motor_on};
                    default: d.rr = `ALHAI_RESP_SLVERR;
                endcase
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{hmode: ALHAI_MODE_PLAIN, kill_en: `ALHAI_KILL_RESET, oof: `ALHAI_OOF_RESET,
                   motor_on: `ALHAI_SERVO_RESET, default: '0};
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Per-axis homing and stop selection
    // ****************************************
    for (genvar g = 0; g < `ALHAI_AXES; g++) begin : g_axis
        alhai_home_if hif ();
        assign hif.start = q.hstart[g];
        assign hif.mode = q.hmode;
        assign hif.home_lvl = q.home_tgl[g];
        assign hif.home_edge = edg[`ALHAI_POS_HOME + g];
        assign hif.idx_rise = edg[`ALHAI_POS_IDX + g] & lvl[`ALHAI_POS_IDX + g];
        assign hif.stopped = axis_stopped[g];
        assign hif.cancel = trip[g] | abort_edge;
        alhai_home_seq u_seq (
            .aclk(aclk),
            .aresetn(aresetn),
            .hif(hif.seq)
        );
        assign busy[g] = hif.busy;
        assign decel[g] = hif.decel;
        assign h_ret[g] = hif.ret;
        assign h_zero[g] = hif.zero;
        assign h_jog[g] = hif.jog;
        assign h_fwd[g] = hif.fwd;
        assign h_slow[g] = hif.slow;
        // Abort beats limit, limit beats the homing ramp-down
        assign axis_stop_sel[2*g +: 2] = q.fast_stop[g] ? ALHAI_STOP_FAST :
                                         q.lim_stop[g] ? ALHAI_STOP_LIMIT :
                                         decel[g] ? ALHAI_STOP_RAMP : ALHAI_STOP_NONE;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = !q.aw_v && !q.bv;
    assign s_axi_wready = !q.w_v && !q.bv;
    assign s_axi_bvalid = q.bv;
    assign s_axi_bresp = q.br;
    assign s_axi_arready = !q.rv;
    assign s_axi_rvalid = q.rv;
    assign s_axi_rdata = q.rd;
    assign s_axi_rresp = q.rr;
    assign motor_enable = q.motor_on;
    assign motion_halt = q.halt;
    assign begin_go = q.go;
    assign begin_fwd = q.go_fwd;
    assign home_jog = h_jog;
    assign home_jog_fwd = h_fwd;
    assign home_slow = h_slow;
    assign home_return = h_ret;
    assign pos_zero_load = h_zero;
    assign thread0_branch = q.branch;
    assign prog_kill = q.kill;
    assign ramp_up_rate = q.rate[0];
    assign ramp_down_rate = q.rate[1];
    assign cruise_rate = q.rate[2];
    assign homing_approach_rate = q.rate[3];
    assign limit_stop_decel = q.rate[4];
endmodule // alhai_core

//--- dv/alhai_core_monitor.sv
// Port-level checks for the limit, home and abort input block
module alhai_core_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] fwd_limit_in,
    input wire logic [7:0] rev_limit_in,
    input wire logic [7:0] fwd_inhibit,
    input wire logic [7:0] rev_inhibit,
    input wire logic abort_in,
    input wire logic motion_halt,
    input wire logic prog_kill,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [7:0] axis_moving,
    input wire logic [15:0] axis_stop_sel
);
    // Single domain, so one clocking and one disable serve all
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_fwd_inhibit_follow: assert property ($stable(fwd_limit_in)[*3] |-> fwd_inhibit == fwd_limit_in) else $error("fwd inhibit");
    a_rev_inhibit_follow: assert property ($stable(rev_limit_in)[*3] |-> rev_inhibit == rev_limit_in) else $error("rev inhibit");
    a_limit_stop_rate: assert property ($rose(fwd_inhibit[0]) && axis_moving[0] |=> axis_stop_sel[1:0] == 2'd1) else $error("limit stop");
    a_halt_cause: assert property (motion_halt |-> $past(abort_in, 3) != $past(abort_in, 4)) else $error("halt cause");
    a_halt_pulse: assert property (motion_halt |=> !motion_halt) else $error("halt width");
    a_abort_kill: assert property (motion_halt |-> prog_kill) else $error("no kill");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_write_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule // alhai_core_monitor

bind alhai_core alhai_core_monitor u_alhai_core_monitor (.aclk, .aresetn, .fwd_limit_in, .rev_limit_in, .fwd_inhibit,
    .rev_inhibit, .abort_in, .motion_halt, .prog_kill, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .axis_moving, .axis_stop_sel);

//--- dv/alhai_switch_model.sv
// Switch and encoder index partner: places requested contact levels on the pins
module alhai_switch_model (
    input wire logic aclk,
    input wire logic [32:0] req,
    output logic [7:0] fwd_limit_in,
    output logic [7:0] rev_limit_in,
    output logic [7:0] home_in,
    output logic [7:0] index_in,
    output logic abort_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contacts open at power up
    initial {abort_in, index_in, home_in, rev_limit_in, fwd_limit_in} = 33'h0;
    // Contacts move only just after an edge, never mid-cycle
    always @(posedge aclk) begin
        {abort_in, index_in, home_in, rev_limit_in, fwd_limit_in} <= req;
    end
endmodule // alhai_switch_model

//--- dv/alhai_core_tb.sv
// Self-checking bench for the limit, home and abort input block
`include "alhai_consts.svh"
module alhai_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, abort_in, thread0_branch;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, axis_moving = 8'h00, axis_stopped = 8'hff;
    logic [7:0] fwd_limit_in, rev_limit_in, home_in, index_in, fwd_inhibit, motor_enable, home_jog;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [23:0] gp_in = 24'h0;
    logic [15:0] axis_stop_sel;
    logic [32:0] req = 33'h0;
    int mismatches = 0, check_count = 0;
    always #50 aclk = ~aclk;
    alhai_switch_model u_alhai_switch_model (.aclk, .req, .fwd_limit_in, .rev_limit_in, .home_in, .index_in, .abort_in);
    alhai_core u_alhai_core (.*, .rev_inhibit(), .motion_halt(), .begin_go(), .begin_fwd(),
        .home_jog_fwd(), .home_slow(), .home_return(), .pos_zero_load(), .prog_kill(),
        .ramp_up_rate(), .ramp_down_rate(), .cruise_rate(), .homing_approach_rate(), .limit_stop_decel());
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // Readies are sampled mid-cycle so the handshake edge is known without a race
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ha = s_axi_awready;
            hw = s_axi_wready;
            hb = s_axi_bvalid;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
        logic ha, hv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hv = 1'b0;
        while (!hv) begin
            @(negedge aclk);
            ha = s_axi_arready;
            hv = s_axi_rvalid;
            q = s_axi_rdata;
            e = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
        end
    endtask
    // Forward limit on a moving axis, then a begin toward it
    task automatic test_limit();
        axis_moving <= 8'h01;
        axis_stopped <= 8'h00;
        wr(`ALHAI_OFF_CTRL, 32'h3);
        req[0] <= 1'b1;
        req[16] <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(fwd_inhibit, 8'h01);
        chk(axis_stop_sel, 16'h1);
        chk(motor_enable, 8'hff);
        chk(thread0_branch, 1'b1);
        rd(`ALHAI_OFF_LIMITS, d, r);
        chk(d, 32'h1);
        rd(`ALHAI_OFF_HOME, d, r);
        chk(d, 32'h1);
        wr(`ALHAI_OFF_BEGIN, 32'h8);
        rd(`ALHAI_OFF_STATUS, d, r);
        chk(d, 32'h16);
    endtask
    // Abort with motor-off-on-fault set on axis 1 only
    task automatic test_abort();
        wr(`ALHAI_OFF_CTRL, 32'h203);
        req[32] <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(motor_enable, 8'hfd);
        chk(axis_stop_sel[5:4], 2'd3);
    endtask
    // Top general input, then an unmapped address
    task automatic test_gpin();
        gp_in <= 24'h800000;
        wr(`ALHAI_OFF_GPIDX, 32'd24);
        rd(`ALHAI_OFF_GPBIT, d, r);
        chk(d, 32'h1);
        rd(8'h3c, d, r);
        chk(r, 2'b10);
    endtask
    // Edge search, axis 3 runs in reverse
    task automatic test_home();
        wr(`ALHAI_OFF_RATE0 + 8'h04, 32'hffff);
        wr(`ALHAI_OFF_BEGIN, 32'h13);
        @(posedge aclk);
        chk(home_jog, 8'h08);
        req[19] <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(home_jog, 8'h00);
    endtask
    task automatic summarize();
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well beyond the few dozen cycles the tests need
    initial begin
        repeat (3000) @(posedge aclk);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        test_limit();
        test_abort();
        test_gpin();
        test_home();
        summarize();
    end
endmodule // alhai_core_tb
